// ===== src/gds_params.svh
`ifndef GDS_PARAMS_SVH
`define GDS_PARAMS_SVH
// Register offsets on the plain register port.
`define GDS_ADDR_PIN 4'h0
`define GDS_ADDR_DELAY 4'h1
`define GDS_ADDR_MAP_UP 4'h2
`define GDS_ADDR_MAP_LO 4'h3
`define GDS_ADDR_CFG 4'h4
`define GDS_ADDR_IRQ_STAT 4'h5
`define GDS_ADDR_IRQ_MASK 4'h6
// Pin control field positions.
`define GDS_PIN_F1_BIT 7
`define GDS_PIN_F0_BIT 6
`define GDS_PIN_DIR_LSB 3
`define GDS_PIN_DATA_LSB 0
// Delay field positions.
`define GDS_DLY_MUX_LSB 8
`define GDS_DLY_GPO_LSB 0
// Channel byte field positions.
`define GDS_CH_PSEL_LSB 5
`define GDS_CH_ORD_LSB 2
`define GDS_CH_EN_BIT 1
`define GDS_CH_OEN_BIT 0
// Configuration field positions.
`define GDS_CFG_SRC_BIT 0
`define GDS_CFG_SEQ_LSB 1
`define GDS_CFG_GPO_LSB 3
`define GDS_CFG_ERR_BIT 8
// Interrupt status bit positions.
`define GDS_IRQ_CONFLICT 0
`define GDS_IRQ_SETTLED 1
`define GDS_IRQ_REFUSED 2
// Reset values.
`define GDS_RST_PIN 8'h40
`define GDS_RST_DELAY 16'h0000
`define GDS_RST_MAP 24'h000000
`define GDS_RST_CFG 6'h02
`define GDS_RST_IRQ 3'h0
// Sequencer mode in which the channel map may drive the pins.
`define GDS_SEQ_MAPPED 2'h3
// Timing in nanoseconds.
`define GDS_CLK_PERIOD_NS 20
`define GDS_MUX_STEP_NS 4000
`define GDS_GPO_STEP_NS 20000
`endif

// ===== src/gds_pkg.sv
`default_nettype none
package gds_pkg;
  typedef logic [23:0] gds_word_t;
  typedef logic [3:0] gds_addr_t;
  typedef logic [2:0] gds_tri_t;
  typedef enum logic [3:0] {
    GDS_IDLE = 4'h1,
    GDS_MUX = 4'h2,
    GDS_GPO = 4'h4,
    GDS_DONE = 4'h8
  } gds_state_t;
endpackage : gds_pkg
`default_nettype wire

// ===== src/gds_regs.sv
// What this block does
// - Pin one is a general pin when its select bit is 1, else sync input.
// - Pin zero is a general pin when its select bit is 1, else clock input.
// - Three direction bits, index matching pin; 1 makes the pin an output.
// - Direction 0 makes an input; its data bit reads the pin level.
// - Outside mapped mode an output pin is driven to the level held in its data bit.
// - Eight-bit multiplexer delay, 4 us per count, zero means no delay.
// - Eight-bit output-pin delay, 20 us per count, zero means no delay.
// - A channel joins the scan only when its scan enable is set.
// - Output enable decides whether selecting the channel activates its pin.
// - Three-bit position field places the channel in the scan order.
// - Three-bit pin select pairs the channel with one pin: codes 0-2 output pins, 3-5 general pins, 6-7 none.
// - Channel map writes are refused while a conversion is active.
// - Mode 3 with source bit set drives pins from the map, else direct.
// - Error flag when two output-enabled channels map one pin; codes 0-2 are outputs 0-2.
`timescale 1ns/10ps
`default_nettype none
`include "gds_params.svh"
module gds_regs #(
  parameter int MUX_STEP_CYC = (`GDS_MUX_STEP_NS + `GDS_CLK_PERIOD_NS - 1) / `GDS_CLK_PERIOD_NS,
  parameter int GPO_STEP_CYC = (`GDS_GPO_STEP_NS + `GDS_CLK_PERIOD_NS - 1) / `GDS_CLK_PERIOD_NS
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port.
  input wire gds_pkg::gds_addr_t addr_in,
  input wire gds_pkg::gds_word_t wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output gds_pkg::gds_word_t rdata_out,
  // Sequencer side.
  input wire logic conv_active_in,
  input wire logic step_req_in,
  input wire gds_pkg::gds_tri_t step_pos_in,
  output gds_pkg::gds_tri_t step_chan_out,
  output logic step_hit_out,
  output logic settle_done_out,
  // Pins.
  input wire gds_pkg::gds_tri_t gpio_pin_in,
  output gds_pkg::gds_tri_t gpio_pin_out,
  output gds_pkg::gds_tri_t gpio_pin_oe_out,
  output gds_pkg::gds_tri_t gpo_out,
  output logic sync_out,
  output logic ext_clock_out,
  // Interrupt.
  output logic irq_out
);
  import gds_pkg::*;

  logic [7:0] pin_direction_value_control_reg;
  logic [15:0] settling_delay_config_reg;
  gds_word_t scan_map_upper_channels_reg;
  gds_word_t scan_map_lower_channels_reg;
  logic [5:0] cfg_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  gds_tri_t pin_meta_reg;
  gds_tri_t pin_sync_reg;
  gds_state_t state_reg;
  // Eighteen bits hold the longest pin wait of 255 steps at the default step length.
  logic [17:0] cnt_reg;
  gds_tri_t chan_reg;
  logic [5:0] act_pin_reg;
  logic conflict_reg;
  logic [47:0] map_w;
  logic mapped_mode_w;
  logic [3:0] lookup_w;
  logic [5:0] act_next_w;
  logic conflict_w;
  logic read_stat_w;

  // Byte of one channel out of the joined map.
  function automatic logic [7:0] chan_byte(input logic [47:0] map, input int ch);
    chan_byte = map[8*ch +: 8];
  endfunction : chan_byte

  // Finds the enabled channel placed at a scan position; lowest index wins a tie.
  function automatic logic [3:0] find_chan(input logic [47:0] map, input gds_tri_t pos);
    logic [7:0] b;
    find_chan = 4'h0;
    for (int ch = 5; ch >= 0; ch--) begin
      b = chan_byte(map, ch);
      if (b[`GDS_CH_EN_BIT] && b[`GDS_CH_ORD_LSB +: 3] == pos) begin
        find_chan = {1'b1, 3'(ch)};
      end
    end
  endfunction : find_chan

  // One-hot pin from a select code: 0-2 output pins, 3-5 general pins, else none.
  function automatic logic [5:0] pin_onehot(input logic [2:0] code);
    pin_onehot = (code < 3'h6) ? 6'(6'h01 << code) : 6'h00;
  endfunction : pin_onehot

  // Only channels that drive a pin can collide on it.
  function automatic logic pin_clash(input logic [47:0] map);
    logic [7:0] a;
    logic [7:0] b;
    pin_clash = 1'b0;
    for (int i = 0; i < 6; i++) begin
      for (int j = i + 1; j < 6; j++) begin
        a = chan_byte(map, i);
        b = chan_byte(map, j);
        if (a[`GDS_CH_OEN_BIT] && b[`GDS_CH_OEN_BIT] &&
            (pin_onehot(a[`GDS_CH_PSEL_LSB +: 3]) & pin_onehot(b[`GDS_CH_PSEL_LSB +: 3])) != 6'h00) begin
          pin_clash = 1'b1;
        end
      end
    end
  endfunction : pin_clash

  // Decoded views of the registers.
  assign map_w = {scan_map_upper_channels_reg, scan_map_lower_channels_reg};
  assign mapped_mode_w = (cfg_reg[`GDS_CFG_SEQ_LSB +: 2] == `GDS_SEQ_MAPPED)
                       && cfg_reg[`GDS_CFG_SRC_BIT];
  assign lookup_w = find_chan(map_w, step_pos_in);
  assign conflict_w = pin_clash(map_w);
  assign read_stat_w = rd_in && (addr_in == `GDS_ADDR_IRQ_STAT);

  // Pin the current channel activates, if its output enable allows it.
  always_comb begin
    logic [7:0] b;
    b = chan_byte(map_w, int'(chan_reg));
    act_next_w = 6'h00;
    if (mapped_mode_w && b[`GDS_CH_OEN_BIT]) begin
      act_next_w = pin_onehot(b[`GDS_CH_PSEL_LSB +: 3]);
    end
  end

  // Pin inputs pass two flip-flops before anything reads them.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end else begin
      pin_meta_reg <= gpio_pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Software writes; the map is frozen while a conversion runs.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_direction_value_control_reg <= `GDS_RST_PIN;
      settling_delay_config_reg <= `GDS_RST_DELAY;
      scan_map_upper_channels_reg <= `GDS_RST_MAP;
      scan_map_lower_channels_reg <= `GDS_RST_MAP;
      cfg_reg <= `GDS_RST_CFG;
      irq_mask_reg <= `GDS_RST_IRQ;
    end else if (wr_in) begin
      // A refused map write keeps the old map; the refusal shows up in the status register.
      case (addr_in)
        `GDS_ADDR_PIN: pin_direction_value_control_reg <= wdata_in[7:0];
        `GDS_ADDR_DELAY: settling_delay_config_reg <= wdata_in[15:0];
        `GDS_ADDR_MAP_UP: begin
          if (!conv_active_in) begin
            scan_map_upper_channels_reg <= wdata_in;
          end
        end
        `GDS_ADDR_MAP_LO: begin
          if (!conv_active_in) begin
            scan_map_lower_channels_reg <= wdata_in;
          end
        end
        `GDS_ADDR_CFG: cfg_reg <= wdata_in[5:0];
        `GDS_ADDR_IRQ_MASK: irq_mask_reg <= wdata_in[2:0];
        default: ;
      endcase
    end
  end

  // Read data in the cycle after the strobe; input pins read their synchronised level.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 24'h000000;
    end else if (rd_in) begin
      case (addr_in)
        `GDS_ADDR_PIN: begin
          // Output pins read back their data bit, input pins the synchronised level.
          rdata_out <= {16'h0000, pin_direction_value_control_reg[7:3],
                        (pin_direction_value_control_reg[`GDS_PIN_DIR_LSB +: 3]
                         & pin_direction_value_control_reg[`GDS_PIN_DATA_LSB +: 3])
                        | (~pin_direction_value_control_reg[`GDS_PIN_DIR_LSB +: 3]
                           & pin_sync_reg)};
        end
        `GDS_ADDR_DELAY: rdata_out <= {8'h00, settling_delay_config_reg};
        `GDS_ADDR_MAP_UP: rdata_out <= scan_map_upper_channels_reg;
        `GDS_ADDR_MAP_LO: rdata_out <= scan_map_lower_channels_reg;
        `GDS_ADDR_CFG: rdata_out <= {15'h0000, conflict_reg, 2'h0, cfg_reg};
        `GDS_ADDR_IRQ_STAT: rdata_out <= {21'h000000, irq_stat_reg};
        `GDS_ADDR_IRQ_MASK: rdata_out <= {21'h000000, irq_mask_reg};
        default: rdata_out <= 24'h000000;
      endcase
    end else begin
      rdata_out <= 24'h000000;
    end
  end

  // Live conflict flag, registered so its rising edge can be an event.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      conflict_reg <= 1'b0;
    end else begin
      conflict_reg <= conflict_w;
    end
  end

  // Sticky events; a new event in the reading cycle survives the clear.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_stat_reg <= `GDS_RST_IRQ;
      irq_out <= 1'b0;
    end else begin
      irq_stat_reg <= (read_stat_w ? 3'h0 : irq_stat_reg)
                    | {wr_in && conv_active_in
                       && (addr_in == `GDS_ADDR_MAP_UP || addr_in == `GDS_ADDR_MAP_LO),
                       state_reg == GDS_DONE,
                       conflict_w && !conflict_reg};
      // The mask gates only the output; status bits record events whether masked or not.
      irq_out <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Settling sequence: mux wait, pin activation, pin wait, done.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= GDS_IDLE;
      cnt_reg <= 18'h00000;
      chan_reg <= 3'h0;
      step_chan_out <= 3'h0;
      step_hit_out <= 1'b0;
      act_pin_reg <= 6'h00;
      settle_done_out <= 1'b0;
    end else begin
      settle_done_out <= 1'b0;
      if (!mapped_mode_w) begin
        act_pin_reg <= 6'h00;
      end
      case (state_reg)
        GDS_IDLE: begin
          if (step_req_in) begin
            chan_reg <= lookup_w[2:0];
            step_chan_out <= lookup_w[2:0];
            step_hit_out <= lookup_w[3];
            act_pin_reg <= 6'h00;
            cnt_reg <= 18'(settling_delay_config_reg[`GDS_DLY_MUX_LSB +: 8] * MUX_STEP_CYC);
            state_reg <= GDS_MUX;
          end
        end
        // A zero count still spends one cycle here, so every settle has a fixed minimum.
        GDS_MUX: begin
          if (cnt_reg != 18'h00000) begin
            cnt_reg <= cnt_reg - 18'h00001;
          end else if (step_hit_out && act_next_w != 6'h00) begin
            act_pin_reg <= act_next_w;
            cnt_reg <= 18'(settling_delay_config_reg[`GDS_DLY_GPO_LSB +: 8] * GPO_STEP_CYC);
            state_reg <= GDS_GPO;
          end else begin
            state_reg <= GDS_DONE;
          end
        end
        GDS_GPO: begin
          if (cnt_reg != 18'h00000) begin
            cnt_reg <= cnt_reg - 18'h00001;
          end else begin
            state_reg <= GDS_DONE;
          end
        end
        GDS_DONE: begin
          settle_done_out <= 1'b1;
          state_reg <= GDS_IDLE;
        end
        default: state_reg <= GDS_IDLE;
      endcase
    end
  end

  // Pin drivers; shared pins give up output drive when used for sync or clock.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      gpio_pin_out <= 3'h0;
      gpio_pin_oe_out <= 3'h0;
      gpo_out <= 3'h0;
      sync_out <= 1'b0;
      ext_clock_out <= 1'b0;
    end else begin
      // Pin two has no second function, so only its direction bit gates its driver.
      gpio_pin_oe_out <= pin_direction_value_control_reg[`GDS_PIN_DIR_LSB +: 3]
                       & {1'b1, pin_direction_value_control_reg[`GDS_PIN_F1_BIT],
                          pin_direction_value_control_reg[`GDS_PIN_F0_BIT]};
      gpio_pin_out <= mapped_mode_w ? act_pin_reg[5:3]
                                    : pin_direction_value_control_reg[2:0];
      gpo_out <= mapped_mode_w ? act_pin_reg[2:0] : cfg_reg[`GDS_CFG_GPO_LSB +: 3];
      // Sync and clock are sampled copies of the pins, so only slow edges pass faithfully.
      sync_out <= !pin_direction_value_control_reg[`GDS_PIN_F1_BIT] && pin_sync_reg[1];
      ext_clock_out <= !pin_direction_value_control_reg[`GDS_PIN_F0_BIT] && pin_sync_reg[0];
    end
  end
endmodule : gds_regs
`default_nettype wire

// ===== verif/gds_pins_model.sv
`timescale 1ns/10ps
`default_nettype none
module gds_pins_model (
  // Design side.
  input wire logic [2:0] oe_in,
  input wire logic [2:0] drive_in,
  // Outside world.
  input wire logic [2:0] ext_in,
  output logic [2:0] pin_out
);
  // A driven pin shows the design's level; a released one shows the outside source.
  assign pin_out = (oe_in & drive_in) | (~oe_in & ext_in);
endmodule : gds_pins_model
`default_nettype wire

// ===== verif/gds_regs_sva.sv
`timescale 1ns/10ps
`default_nettype none
module gds_regs_sva #(
  parameter int MUX_STEP_CYC = 200,
  parameter int GPO_STEP_CYC = 1000
) (
  // Clock, reset and register port.
  input wire logic clk_in,
  input wire logic rst_in,
  input wire gds_pkg::gds_addr_t addr_in,
  input wire gds_pkg::gds_word_t wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire gds_pkg::gds_word_t rdata_out,
  // Sequencer side.
  input wire logic conv_active_in,
  input wire logic step_req_in,
  input wire gds_pkg::gds_tri_t step_pos_in,
  input wire gds_pkg::gds_tri_t step_chan_out,
  input wire logic step_hit_out,
  input wire logic settle_done_out,
  // Pins and interrupt.
  input wire gds_pkg::gds_tri_t gpio_pin_in,
  input wire gds_pkg::gds_tri_t gpio_pin_out,
  input wire gds_pkg::gds_tri_t gpio_pin_oe_out,
  input wire gds_pkg::gds_tri_t gpo_out,
  input wire logic sync_out,
  input wire logic ext_clock_out,
  input wire logic irq_out
);
  localparam int WAIT_MAX = 8 + 255 * (MUX_STEP_CYC + GPO_STEP_CYC);
  logic busy_reg;
  logic [19:0] wait_reg;
  logic taken;
  // A request counts only when the sequencer is idle or just finishing.
  assign taken = step_req_in && (!busy_reg || settle_done_out);
  // Mirror of the busy span, so the longest settle can be bounded by a counter.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_reg <= 1'b0;
      wait_reg <= '0;
    end else begin
      busy_reg <= taken || (busy_reg && !settle_done_out);
      wait_reg <= taken ? 20'h00000 : wait_reg + 20'h00001;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_rd_idle; !rd_in |=> rdata_out == '0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_oe_write;
    (wr_in && addr_in == 4'h0) ##1 !(wr_in && addr_in == 4'h0) |-> ##1
      gpio_pin_oe_out == ($past(wdata_in[5:3], 2) & {1'b1, $past(wdata_in[7:6], 2)});
  endproperty
  a_oe_write: assert property (p_oe_write) else $error("enable mismatch");
  property p_sync_off; gpio_pin_oe_out[1] && $past(gpio_pin_oe_out[1]) |-> !sync_out; endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync while general");
  property p_clk_off; gpio_pin_oe_out[0] && $past(gpio_pin_oe_out[0]) |-> !ext_clock_out; endproperty
  a_clk_off: assert property (p_clk_off) else $error("clock while general");
  property p_hit_chan; !step_hit_out |-> step_chan_out == 3'h0; endproperty
  a_hit_chan: assert property (p_hit_chan) else $error("channel without hit");
  property p_hit_stable; !taken |=> $stable(step_hit_out) && $stable(step_chan_out); endproperty
  a_hit_stable: assert property (p_hit_stable) else $error("step result moved");
  property p_settle_bound; busy_reg |-> wait_reg <= WAIT_MAX; endproperty
  a_settle_bound: assert property (p_settle_bound) else $error("settle too long");
  property p_no_settle_idle; !busy_reg |-> !settle_done_out; endproperty
  a_no_settle_idle: assert property (p_no_settle_idle) else $error("settle when idle");
  c_taken: cover property (taken);
  c_settle: cover property (settle_done_out);
  c_irq: cover property (irq_out);
endmodule : gds_regs_sva
bind gds_regs gds_regs_sva #(.MUX_STEP_CYC(MUX_STEP_CYC), .GPO_STEP_CYC(GPO_STEP_CYC)) u_sva (
  .clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .conv_active_in,
  .step_req_in, .step_pos_in, .step_chan_out, .step_hit_out, .settle_done_out, .gpio_pin_in,
  .gpio_pin_out, .gpio_pin_oe_out, .gpo_out, .sync_out, .ext_clock_out, .irq_out);
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import gds_pkg::*;
  localparam int MS = 2;
  localparam int GS = 3;
  logic clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
  logic conv_active_in = 1'b0, step_req_in = 1'b0;
  gds_addr_t addr_in = '0;
  gds_word_t wdata_in = '0, rdata_out;
  gds_tri_t step_pos_in = '0, ext_lvl = 3'h5;
  gds_tri_t step_chan_out, gpio_pin_in, gpio_pin_out, gpio_pin_oe_out, gpo_out;
  logic step_hit_out, settle_done_out, sync_out, ext_clock_out, irq_out;
  gds_word_t rst_exp [8] = '{24'h45, 0, 0, 0, 24'h2, 0, 0, 0};
  int n_mismatch = 0, comparisons = 0, t0, t1;
  // Free-running 50 MHz clock.
  always #10 clk_in = ~clk_in;
  gds_regs #(.MUX_STEP_CYC(MS), .GPO_STEP_CYC(GS)) u_gds_regs (.clk_in, .rst_in, .addr_in,
    .wdata_in, .wr_in, .rd_in, .rdata_out, .conv_active_in, .step_req_in, .step_pos_in,
    .step_chan_out, .step_hit_out, .settle_done_out, .gpio_pin_in, .gpio_pin_out,
    .gpio_pin_oe_out, .gpo_out, .sync_out, .ext_clock_out, .irq_out);
  gds_pins_model u_gds_pins_model (.oe_in(gpio_pin_oe_out), .drive_in(gpio_pin_out),
    .ext_in(ext_lvl), .pin_out(gpio_pin_in));
  // Verdict and end of run.
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input gds_addr_t a, input gds_word_t d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  // Read data is looked at only in the cycle after the strobe.
  task automatic rd(input gds_addr_t a, input gds_word_t e);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk($sformatf("reg%0h", a), e, rdata_out);
  endtask : rd
  task automatic waitc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : waitc
  // One scan step; n counts edges until the settle pulse, bounded against hangs.
  task automatic step(input gds_tri_t p, output int n);
    @(posedge clk_in);
    step_req_in <= 1'b1;
    step_pos_in <= p;
    @(posedge clk_in);
    step_req_in <= 1'b0;
    n = 0;
    #1;
    while (settle_done_out !== 1'b1) begin
      @(posedge clk_in);
      #1 n++;
      if (n > 2000) begin
        n_mismatch++;
        final_report();
      end
    end
  endtask : step
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'h0;
    // Two edges let the pin synchroniser fill before the first pin read.
    waitc(2);
    for (int a = 0; a < 7; a++) rd(4'(a), rst_exp[a]);
    rd(4'hf, 24'h0);
    wr(4'h0, 24'h0000da);
    waitc(3);
    chk("oe", 3'h3, gpio_pin_oe_out);
    chk("drive", 3'h2, gpio_pin_out);
    rd(4'h0, 24'h0000de);
    wr(4'h0, 24'h000018);
    // The pin level needs the enable edge, two sync stages and the output flop.
    waitc(5);
    chk("oe off", 3'h0, gpio_pin_oe_out);
    chk("sync clk", 2'h1, {sync_out, ext_clock_out});
    ext_lvl <= 3'h2;
    waitc(5);
    chk("sync clk", 2'h2, {sync_out, ext_clock_out});
    // Mapped mode: channel 4 at position 5 drives output pin 1.
    wr(4'h4, 24'h000007);
    wr(4'h2, 24'h003700);
    wr(4'h3, 24'h180000);
    step(3'h5, t0);
    chk("step", 4'hc, {step_hit_out, step_chan_out});
    chk("gpo", 3'h2, gpo_out);
    wr(4'h1, 24'h000200);
    step(3'h5, t1);
    chk("mux wait", t0 + 2 * MS, t1);
    wr(4'h1, 24'h000001);
    step(3'h5, t1);
    chk("pin wait", t0 + GS, t1);
    step(3'h6, t1);
    chk("miss", 4'h0, {step_hit_out, step_chan_out});
    wr(4'h2, 24'h003600);
    step(3'h5, t1);
    chk("no pin", 3'h0, gpo_out);
    chk("no pin wait", 1'h1, t1 < t0 + GS);
    wr(4'h4, 24'h00002b);
    waitc(3);
    chk("direct", 3'h5, gpo_out);
    // Conflict raises the interrupt; reading status clears it.
    wr(4'h2, 24'h003700);
    wr(4'h6, 24'h000005);
    rd(4'h5, 24'h000002);
    wr(4'h3, 24'h180021);
    waitc(3);
    chk("irq", 1'h1, irq_out);
    rd(4'h4, 24'h00012b);
    rd(4'h5, 24'h000001);
    waitc(2);
    chk("irq", 1'h0, irq_out);
    @(posedge clk_in) conv_active_in <= 1'h1;
    wr(4'h2, 24'hffffff);
    rd(4'h2, 24'h003700);
    rd(4'h5, 24'h000004);
    @(posedge clk_in) conv_active_in <= 1'h0;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
